// file: hw/usb_ep_pkg.sv
// shared constants and types for the usb endpoint manager and its firmware-side controller
package usb_ep_pkg;
  localparam int NUM_EP = 4;
  localparam int EP_W = 2;
  localparam int RAM_BYTES = 8192;
  localparam int RAM_WORDS = 2048;
  localparam int RAM_AW = 11;
  localparam int BA_W = 13;
  localparam int BLK_W = 12;
  localparam int CUM_W = 15;
  localparam int WIN_AW = 16;
  localparam int LEN_W = 11;
  localparam int SIZE_W = 3;
  localparam int BANK_W = 2;
  localparam int NTR_W = 2;
  localparam int CMD_W = 16;
  localparam logic [BANK_W-1:0] MAX_BANKS = 2'h2;
  localparam logic [BANK_W-1:0] ONE_BANK = 2'h1;
  localparam logic [NTR_W-1:0] ONE_TRANS = 2'h1;
  localparam logic [LEN_W-1:0] SIZE_MIN_BYTES = 11'h008;
  localparam logic [SIZE_W-1:0] SIZE_ISO_ONLY = 3'h7;
  // command data layout for configuration and enable
  localparam int CFG_SIZE_LSB = 0;
  localparam int CFG_DIR_BIT = 3;
  localparam int CFG_TYPE_LSB = 4;
  localparam int CFG_BANK_LSB = 6;
  localparam int CFG_NTR_LSB = 8;
  localparam int IEN_OUT_BIT = 0;
  localparam int IEN_IN_BIT = 1;
  // per-endpoint status word
  localparam int FL_OUT_RX = 0;
  localparam int FL_IN_RDY = 1;
  localparam int FL_IN_DONE = 2;
  localparam int FL_TRERR = 3;
  localparam int FL_FLOW = 4;
  localparam int FL_CRC = 5;
  localparam int FL_KILL = 6;
  localparam int FL_MAPPED = 7;
  localparam int FL_EN = 8;
  localparam int FL_BUSY_LSB = 9;
  localparam int FLAG_W = 11;
  typedef enum logic [1:0] {EPT_CTRL, EPT_ISO, EPT_BULK, EPT_INT} ep_type_e;
  typedef enum logic [2:0] {CMD_CFG, CMD_ENABLE, CMD_DISABLE, CMD_RESET, CMD_CLR_OUT, CMD_SET_IN, CMD_KILL,
                            CMD_CLR_DONE} cmd_op_e;
  typedef enum logic {H_IDLE, H_RD_WAIT} host_state_e;
  // apb register map of the controller
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] REG_CMD = 12'h000;
  localparam logic [APB_AW-1:0] REG_WIN_ADDR = 12'h004;
  localparam logic [APB_AW-1:0] REG_WIN_DATA = 12'h008;
  localparam logic [APB_AW-1:0] REG_ERR = 12'h00C;
  localparam logic [APB_AW-1:0] REG_STS0 = 12'h010;
  localparam logic [APB_AW-1:0] REG_STS_END = 12'h020;
  localparam int CMD_EP_LSB = 16;
  localparam int CMD_OP_LSB = 20;
  localparam int WIN_EP_LSB = 16;
  localparam int ERR_SIZE_BIT = 0;
  localparam int ERR_MAP_BIT = 1;
  localparam int ERR_KILL_BIT = 2;
  localparam int ERR_W = 3;
  localparam logic [WIN_AW-1:0] WORD_STEP = 16'h0004;

  function automatic logic [LEN_W-1:0] ep_bytes(input logic [SIZE_W-1:0] code);
    return SIZE_MIN_BYTES << code;
  endfunction

  function automatic logic [BLK_W-1:0] ep_block(input logic [SIZE_W-1:0] code, input logic [BANK_W-1:0] banks);
    return (banks == MAX_BANKS) ? {ep_bytes(code), 1'h0} : {1'h0, ep_bytes(code)};
  endfunction
endpackage

// file: hw/ep_mgr_if.sv
// link between the endpoint manager and its firmware-side controller
interface ep_mgr_if
  import usb_ep_pkg::*;
(
  input logic clock,
  input logic reset_n
);
  logic cmd_valid;
  cmd_op_e cmd_op;
  logic [EP_W-1:0] cmd_ep;
  logic [CMD_W-1:0] cmd_data;
  logic win_valid;
  logic win_write;
  logic [EP_W-1:0] win_ep;
  logic [WIN_AW-1:0] win_addr;
  logic [31:0] win_wdata;
  logic [31:0] win_rdata;
  logic win_rvalid;
  logic [NUM_EP-1:0][FLAG_W-1:0] sts;
  logic [NUM_EP-1:0] ep_irq;

  modport dev (
    input clock, reset_n, cmd_valid, cmd_op, cmd_ep, cmd_data, win_valid, win_write, win_ep, win_addr, win_wdata,
    output win_rdata, win_rvalid, sts, ep_irq
  );
  modport fw (
    input clock, reset_n, win_rdata, win_rvalid, sts, ep_irq,
    output cmd_valid, cmd_op, cmd_ep, cmd_data, win_valid, win_write, win_ep, win_addr, win_wdata
  );
endinterface // ep_mgr_if

// file: hw/usb_ep_device.sv
// endpoint manager: configuration, buffer allocation, logical window and handshake flags
// Overview of operation
// - endpoint 0 is control, enabled at end-reset
// - firmware sets size, direction, type, banks, transactions
// - control endpoints ignore the direction setting
// - mapped flag only when allocation fits; check first
// - control endpoints use one bank, may interrupt
// - other endpoints bulk/interrupt/iso; packet max equals size
// - size 1024 only for isochronous endpoints
// - all endpoints share one 8 Kbyte buffer
// - endpoint block aliased over 64 Kbyte window
// - out-received set on store, firmware clears it
// - out-set or in-ready-clear interrupts only when enabled
// - reset or disable endpoint clears its flags
// - kill bank frees ready bank unless sending
// - firmware waits for kill bit clear first
// - in-complete set after packet sent
// - in-ready cleared when packet sent
// - iso toggle fault sets error (above one transaction) until good set
// - clearing out-received discards bad transactions
// - iso underflow or overflow sets flow error
// - iso crc flag follows each received packet
module usb_ep_device
  import usb_ep_pkg::*;
(
  ep_mgr_if.dev link,
  input logic usb_bus_reset,
  input logic usb_end_reset,
  input logic usb_out_stored,
  input logic [EP_W-1:0] usb_out_ep,
  input logic [LEN_W-1:0] usb_out_len,
  input logic usb_out_crc_bad,
  input logic usb_out_toggle_err,
  input logic usb_in_sent,
  input logic usb_in_token,
  input logic [EP_W-1:0] usb_in_ep,
  input logic [NUM_EP-1:0] usb_in_sending,
  output logic [NUM_EP-1:0] ep_active
);
  logic [NUM_EP-1:0][SIZE_W-1:0] size_w;
  logic [NUM_EP-1:0][BANK_W-1:0] bank_w;
  logic [NUM_EP-1:0] cfgd_w;
  logic [NUM_EP-1:0] fits;
  logic [NUM_EP-1:0] mapped_w;
  logic [NUM_EP-1:0][BA_W-1:0] base_w;
  logic [NUM_EP-1:0][BLK_W-1:0] block_w;
  logic [CUM_W-1:0] cum;
  logic [BLK_W-1:0] win_mask;
  logic [BA_W-1:0] phys;
  logic win_ok;
  logic [31:0] ram_q [RAM_WORDS];
  logic [31:0] rdata_q;
  logic rvalid_q;

  // shared buffer: endpoints are packed in index order
  always_comb
  begin
    cum = '0;
    for (int k = 0; k < NUM_EP; k++)
    begin
      base_w[k] = cum[BA_W-1:0];
      block_w[k] = ep_block(size_w[k], bank_w[k]);
      if (cfgd_w[k])
        cum = cum + CUM_W'(block_w[k]);
      fits[k] = cfgd_w[k] && (bank_w[k] != '0) && (bank_w[k] <= MAX_BANKS) && (cum <= CUM_W'(RAM_BYTES));
    end
  end

  always_comb
  begin
    win_mask = block_w[link.win_ep] - BLK_W'(1);
    phys = base_w[link.win_ep] + BA_W'(link.win_addr[BLK_W-1:0] & win_mask);
    win_ok = link.win_valid && mapped_w[link.win_ep];
  end

  // buffer contents need no reset; unmapped accesses never touch it
  always_ff @(posedge link.clock)
  begin
    if (win_ok && link.win_write)
      ram_q[phys[BA_W-1:2]] <= link.win_wdata;
  end

  always_ff @(posedge link.clock or negedge link.reset_n)
  begin
    if (!link.reset_n)
    begin
      rdata_q <= '0;
      rvalid_q <= 1'h0;
    end
    else
    begin
      rvalid_q <= link.win_valid && !link.win_write;
      if (link.win_valid && !link.win_write)
        rdata_q <= win_ok ? ram_q[phys[BA_W-1:2]] : '0;
    end
  end

  assign link.win_rdata = rdata_q;
  assign link.win_rvalid = rvalid_q;

  for (genvar i = 0; i < NUM_EP; i++)
  begin : g_ep
    localparam logic [EP_W-1:0] EP_ID = EP_W'(i);
    logic [SIZE_W-1:0] size_q;
    logic dir_q;
    ep_type_e type_q;
    logic [BANK_W-1:0] bank_q;
    logic [NTR_W-1:0] ntr_q;
    logic cfgd_q, en_q, armed_q, ien_out_q, ien_in_q, mapped_q;
    logic [BANK_W-1:0] busy_q;
    logic [BANK_W-1:0] busy_d;
    logic [BANK_W:0] busy_n;
    logic out_rx_q, in_rdy_q, in_done_q, trerr_q, flow_q, crc_q, kill_q, in_clr_ev_q, irq_q;
    logic hit, ctrl, iso, in_dir, out_ok, full, out_ev, out_take, out_drop, set_in, sent;
    logic kill, kill_ok, kill_ref, clr_out, clr_done, clr_all, token_miss, in_rdy_d;
    ep_type_e new_type;

    always_comb
    begin
      hit = link.cmd_valid && (link.cmd_ep == EP_ID);
      new_type = ep_type_e'(link.cmd_data[CFG_TYPE_LSB +: 2]);
      if (i == 0)
        new_type = EPT_CTRL;
      else if (new_type == EPT_CTRL)
        new_type = EPT_BULK;
      ctrl = (type_q == EPT_CTRL);
      iso = (type_q == EPT_ISO);
      in_dir = !ctrl && dir_q;
      out_ok = ctrl || !dir_q;
      full = (busy_q == bank_q);
      // packet no longer than endpoint size
      out_ev = en_q && usb_out_stored && (usb_out_ep == EP_ID) && out_ok && (usb_out_len <= ep_bytes(size_q));
      out_take = out_ev && !full;
      out_drop = out_ev && full;
      clr_out = hit && (link.cmd_op == CMD_CLR_OUT) && out_ok;
      clr_done = hit && (link.cmd_op == CMD_CLR_DONE);
      set_in = hit && (link.cmd_op == CMD_SET_IN) && (ctrl || in_dir) && en_q && !full;
      sent = usb_in_sent && (usb_in_ep == EP_ID) && (busy_q != '0);
      kill = hit && (link.cmd_op == CMD_KILL) && in_dir;
      // one busy bank on the line cannot be killed
      kill_ok = kill && (busy_q > {1'h0, usb_in_sending[i] || sent});
      kill_ref = kill && !kill_ok && (busy_q != '0);
      token_miss = iso && in_dir && en_q && usb_in_token && (usb_in_ep == EP_ID) && (busy_q == '0);
      // endpoint reset or disable, bus reset
      clr_all = usb_bus_reset || (hit && ((link.cmd_op == CMD_DISABLE) || (link.cmd_op == CMD_RESET)));
      busy_n = {1'h0, busy_q} + {2'h0, out_take || set_in};
      busy_n = busy_n - {2'h0, sent} - {2'h0, kill_ok};
      // a transaction error discards every stored bank
      if (clr_out)
        busy_n = trerr_q ? '0 : busy_n - {2'h0, busy_q != '0};
      busy_d = clr_all ? '0 : busy_n[BANK_W-1:0];
      // ready reads clear while a bank is still free
      if (clr_all)
        in_rdy_d = 1'h0;
      else if (ctrl)
        in_rdy_d = (in_rdy_q || set_in) && !sent;
      else
        in_rdy_d = in_dir && (busy_d == bank_q);
    end

    always_ff @(posedge link.clock or negedge link.reset_n)
    begin
      if (!link.reset_n)
      begin
        size_q <= '0;
        dir_q <= 1'h0;
        type_q <= EPT_CTRL;
        bank_q <= ONE_BANK;
        ntr_q <= ONE_TRANS;
        cfgd_q <= 1'h0;
      end
      else if (hit && (link.cmd_op == CMD_CFG))
      begin
        size_q <= link.cmd_data[CFG_SIZE_LSB +: SIZE_W];
        dir_q <= link.cmd_data[CFG_DIR_BIT];
        type_q <= new_type;
        bank_q <= (new_type == EPT_CTRL) ? ONE_BANK : link.cmd_data[CFG_BANK_LSB +: BANK_W];
        ntr_q <= link.cmd_data[CFG_NTR_LSB +: NTR_W];
        cfgd_q <= 1'h1;
      end
    end

    always_ff @(posedge link.clock or negedge link.reset_n)
    begin
      if (!link.reset_n)
      begin
        en_q <= 1'h0;
        armed_q <= 1'h0;
        ien_out_q <= 1'h0;
        ien_in_q <= 1'h0;
        mapped_q <= 1'h0;
      end
      else
      begin
        mapped_q <= fits[i];
        if (hit && (link.cmd_op == CMD_DISABLE))
        begin
          en_q <= 1'h0;
          armed_q <= 1'h0;
        end
        else if (usb_bus_reset)
          en_q <= 1'h0;
        // endpoint 0 comes up at end of bus reset
        else if ((i == 0) && usb_end_reset)
          en_q <= armed_q && mapped_q;
        // enabling an unmapped endpoint is ignored
        else if (hit && (link.cmd_op == CMD_ENABLE) && mapped_q)
        begin
          if (i == 0)
            armed_q <= 1'h1;
          else
            en_q <= 1'h1;
          ien_out_q <= link.cmd_data[IEN_OUT_BIT];
          ien_in_q <= link.cmd_data[IEN_IN_BIT];
        end
      end
    end

    always_ff @(posedge link.clock or negedge link.reset_n)
    begin
      if (!link.reset_n)
      begin
        busy_q <= '0;
        in_rdy_q <= 1'h0;
        out_rx_q <= 1'h0;
        in_done_q <= 1'h0;
        trerr_q <= 1'h0;
        flow_q <= 1'h0;
        crc_q <= 1'h0;
        kill_q <= 1'h0;
        in_clr_ev_q <= 1'h0;
      end
      else
      begin
        busy_q <= busy_d;
        in_rdy_q <= in_rdy_d;
        kill_q <= kill && !clr_all;
        if (clr_all)
        begin
          out_rx_q <= 1'h0;
          in_done_q <= 1'h0;
          trerr_q <= 1'h0;
          flow_q <= 1'h0;
          crc_q <= 1'h0;
          in_clr_ev_q <= 1'h0;
        end
        else
        begin
          // stays set while another bank holds data
          out_rx_q <= out_take || (out_rx_q && !clr_out) || (clr_out && (busy_d != '0));
          // sent packet or refused kill sets complete
          in_done_q <= sent || kill_ref || (in_done_q && !clr_done);
          if (out_take && iso && (ntr_q > ONE_TRANS))
            trerr_q <= usb_out_toggle_err;
          flow_q <= (iso && out_drop) || token_miss || (flow_q && !clr_done);
          if (out_take && iso)
            crc_q <= usb_out_crc_bad;
          in_clr_ev_q <= (in_rdy_q && !in_rdy_d) || (in_clr_ev_q && !clr_done);
        end
      end
    end

    // interrupt gated by the endpoint enables
    always_ff @(posedge link.clock or negedge link.reset_n)
    begin
      if (!link.reset_n)
        irq_q <= 1'h0;
      else
        irq_q <= (out_rx_q && ien_out_q) || (in_clr_ev_q && ien_in_q);
    end

    assign size_w[i] = size_q;
    assign bank_w[i] = bank_q;
    assign cfgd_w[i] = cfgd_q;
    assign mapped_w[i] = mapped_q;
    assign ep_active[i] = en_q;
    assign link.ep_irq[i] = irq_q;
    assign link.sts[i] = {busy_q, en_q, mapped_q, kill_q, crc_q, flow_q, trerr_q, in_done_q, in_rdy_q, out_rx_q};
  end
endmodule // usb_ep_device

// file: hw/usb_ep_fw_ctrl.sv
// firmware-side controller: apb registers turned into endpoint manager commands
module usb_ep_fw_ctrl
  import usb_ep_pkg::*;
(
  ep_mgr_if.fw link,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [APB_AW-1:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  host_state_e state_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic cmd_valid_q;
  cmd_op_e cmd_op_q;
  logic [EP_W-1:0] cmd_ep_q;
  logic [CMD_W-1:0] cmd_data_q;
  logic win_valid_q, win_write_q;
  logic [EP_W-1:0] win_ep_q, req_ep_q;
  logic [WIN_AW-1:0] win_addr_q, req_addr_q;
  logic [31:0] win_wdata_q;
  logic [ERR_W-1:0] err_q;
  logic [ERR_W-1:0] err_set;
  logic access, is_sts;
  cmd_op_e op;
  logic [EP_W-1:0] cep;
  logic [FLAG_W-1:0] csts;

  always_comb
  begin
    access = psel && penable && !pready_q && (state_q == H_IDLE);
    op = cmd_op_e'(pwdata[CMD_OP_LSB +: 3]);
    cep = pwdata[CMD_EP_LSB +: EP_W];
    csts = link.sts[cep];
    is_sts = (paddr >= REG_STS0) && (paddr < REG_STS_END) && (paddr[1:0] == 2'h0);
    err_set = '0;
    if (access && pwrite && (paddr == REG_CMD))
    begin
      // the largest size is kept for isochronous use
      err_set[ERR_SIZE_BIT] = (op == CMD_CFG) && (pwdata[CFG_SIZE_LSB +: SIZE_W] == SIZE_ISO_ONLY)
                              && (ep_type_e'(pwdata[CFG_TYPE_LSB +: 2]) != EPT_ISO);
      err_set[ERR_MAP_BIT] = (op == CMD_ENABLE) && !csts[FL_MAPPED];
      // no second kill while one is pending
      err_set[ERR_KILL_BIT] = (op == CMD_KILL) && csts[FL_KILL];
    end
  end

  always_ff @(posedge link.clock or negedge link.reset_n)
  begin
    if (!link.reset_n)
    begin
      state_q <= H_IDLE;
      prdata_q <= '0;
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
      cmd_valid_q <= 1'h0;
      cmd_op_q <= CMD_CFG;
      cmd_ep_q <= '0;
      cmd_data_q <= '0;
      win_valid_q <= 1'h0;
      win_write_q <= 1'h0;
      win_wdata_q <= '0;
      req_ep_q <= '0;
      req_addr_q <= '0;
    end
    else
    begin
      pready_q <= 1'h0;
      cmd_valid_q <= 1'h0;
      win_valid_q <= 1'h0;
      case (state_q)
        H_IDLE:
          if (access)
          begin
            pready_q <= 1'h1;
            pslverr_q <= 1'h0;
            prdata_q <= '0;
            if (paddr == REG_CMD)
            begin
              // configuration is passed through as written
              if (pwrite && (err_set == '0))
              begin
                cmd_valid_q <= 1'h1;
                cmd_op_q <= op;
                cmd_ep_q <= cep;
                cmd_data_q <= pwdata[CMD_W-1:0];
              end
            end
            else if (paddr == REG_WIN_ADDR)
              prdata_q <= {14'h0000, win_ep_q, win_addr_q};
            else if (paddr == REG_WIN_DATA)
            begin
              win_valid_q <= 1'h1;
              win_write_q <= pwrite;
              win_wdata_q <= pwdata;
              req_ep_q <= win_ep_q;
              req_addr_q <= win_addr_q;
              if (!pwrite)
              begin
                pready_q <= 1'h0;
                state_q <= H_RD_WAIT;
              end
            end
            else if (paddr == REG_ERR)
              prdata_q <= 32'(err_q);
            else if (is_sts && !pwrite)
              prdata_q <= 32'(link.sts[paddr[EP_W+1:2]]);
            else
              pslverr_q <= 1'h1;
          end
        H_RD_WAIT:
          if (link.win_rvalid)
          begin
            prdata_q <= link.win_rdata;
            pready_q <= 1'h1;
            state_q <= H_IDLE;
          end
        default:
          state_q <= H_IDLE;
      endcase
    end
  end

  // window pointer steps one word per data access so a buffer streams linearly
  always_ff @(posedge link.clock or negedge link.reset_n)
  begin
    if (!link.reset_n)
    begin
      win_ep_q <= '0;
      win_addr_q <= '0;
    end
    else if (access && pwrite && (paddr == REG_WIN_ADDR))
    begin
      win_ep_q <= pwdata[WIN_EP_LSB +: EP_W];
      win_addr_q <= pwdata[WIN_AW-1:0];
    end
    else if (access && (paddr == REG_WIN_DATA))
      win_addr_q <= win_addr_q + WORD_STEP;
  end

  // refusal bits: write one to clear, a new refusal wins
  always_ff @(posedge link.clock or negedge link.reset_n)
  begin
    if (!link.reset_n)
      err_q <= '0;
    else if (access && pwrite && (paddr == REG_ERR))
      err_q <= err_set | (err_q & ~pwdata[ERR_W-1:0]);
    else
      err_q <= err_set | err_q;
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign link.cmd_valid = cmd_valid_q;
  assign link.cmd_op = cmd_op_q;
  assign link.cmd_ep = cmd_ep_q;
  assign link.cmd_data = cmd_data_q;
  assign link.win_valid = win_valid_q;
  assign link.win_write = win_write_q;
  assign link.win_ep = req_ep_q;
  assign link.win_addr = req_addr_q;
  assign link.win_wdata = win_wdata_q;
endmodule // usb_ep_fw_ctrl

// file: dv/ep_mgr_asserts.sv
// concurrent checks on the link between endpoint manager and controller
module ep_mgr_asserts
  import usb_ep_pkg::*;
(
  input logic clock,
  input logic reset_n,
  input logic cmd_valid,
  input cmd_op_e cmd_op,
  input logic [EP_W-1:0] cmd_ep,
  input logic [CMD_W-1:0] cmd_data,
  input logic win_valid,
  input logic win_write,
  input logic win_rvalid,
  input logic [NUM_EP-1:0][FLAG_W-1:0] sts,
  input logic [NUM_EP-1:0] ep_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_rd; win_valid && !win_write |=> win_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("window read not answered");
  property p_rst; cmd_valid && cmd_op == CMD_RESET |=> sts[$past(cmd_ep)][FL_CRC:FL_OUT_RX] == '0; endproperty
  a_rst: assert property (p_rst) else $error("endpoint reset left a flag");
  property p_dis;
    // mapped survives a disable: the allocation stays until this or a lower-numbered endpoint is reconfigured
    cmd_valid && cmd_op == CMD_DISABLE |=> sts[$past(cmd_ep)][FL_KILL:FL_OUT_RX] == '0
      && !sts[$past(cmd_ep)][FL_EN];
  endproperty
  a_dis: assert property (p_dis) else $error("disable left a flag");
  property p_irq; cmd_valid && cmd_op == CMD_DISABLE |=> ##1 !ep_irq[$past(cmd_ep, 2)]; endproperty
  a_irq: assert property (p_irq) else $error("interrupt after disable");
  property p_kill;
    cmd_valid && cmd_op == CMD_KILL |=> sts[$past(cmd_ep)][FL_KILL] ##1 !sts[$past(cmd_ep, 2)][FL_KILL];
  endproperty
  a_kill: assert property (p_kill) else $error("kill bit not a single cycle");
  property p_map;
    cmd_valid && cmd_op == CMD_CFG && cmd_ep != 0 && cmd_data[CFG_BANK_LSB+:2] inside {2'h0, 2'h3}
      |-> ##2 !sts[$past(cmd_ep, 2)][FL_MAPPED];
  endproperty
  a_map: assert property (p_map) else $error("bad bank count mapped");
  property p_ep0; sts[0][FL_BUSY_LSB+:BANK_W] <= ONE_BANK; endproperty
  a_ep0: assert property (p_ep0) else $error("control endpoint above one bank");
  property p_en; $rose(sts[1][FL_EN]) |-> sts[1][FL_MAPPED]; endproperty
  a_en: assert property (p_en) else $error("unmapped endpoint enabled");
  c_kill: cover property (cmd_valid && cmd_op == CMD_KILL);
  c_rd: cover property (win_rvalid);
  c_irq: cover property ($rose(ep_irq[1]));
endmodule // ep_mgr_asserts

// file: dv/testbench.sv
// self-checking bench: firmware controller and endpoint manager joined by their link
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import usb_ep_pkg::*;
  logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, sl;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, d;
  logic usb_bus_reset = 0, usb_end_reset = 0, usb_out_stored = 0, usb_out_crc_bad = 0;
  logic usb_out_toggle_err = 0, usb_in_sent = 0, usb_in_token = 0;
  logic [EP_W-1:0] usb_out_ep = '0, usb_in_ep = '0;
  logic [LEN_W-1:0] usb_out_len = '0;
  logic [NUM_EP-1:0] usb_in_sending = '0, ep_active;
  logic [15:0] a;
  int err_count = 0, cmp_count = 0, seed = 62545;
  always #2.5 clock = ~clock;
  ep_mgr_if lnk (.clock(clock), .reset_n(reset_n));
  usb_ep_device usb_ep_device_i (.link(lnk), .usb_bus_reset, .usb_end_reset, .usb_out_stored, .usb_out_ep,
    .usb_out_len, .usb_out_crc_bad, .usb_out_toggle_err, .usb_in_sent, .usb_in_token, .usb_in_ep,
    .usb_in_sending, .ep_active);
  usb_ep_fw_ctrl usb_ep_fw_ctrl_i (.link(lnk), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  ep_mgr_asserts ep_mgr_asserts_i (.clock(lnk.clock), .reset_n(lnk.reset_n), .cmd_valid(lnk.cmd_valid),
    .cmd_op(lnk.cmd_op), .cmd_ep(lnk.cmd_ep), .cmd_data(lnk.cmd_data), .win_valid(lnk.win_valid),
    .win_write(lnk.win_write), .win_rvalid(lnk.win_rvalid), .sts(lnk.sts), .ep_irq(lnk.ep_irq));

  task automatic final_report();
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [APB_AW-1:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'h1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    rd = prdata;
    sl = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1)
    begin
      err_count++;
      final_report();
    end
    @(posedge clock);
  endtask

  function automatic logic [15:0] cfg(input logic [2:0] s, input logic dr, input ep_type_e t, input logic [1:0] b,
                                      input logic [1:0] nt);
    return {6'h0, nt, b, t, dr, s};
  endfunction

  // block length that one endpoint occupies in the buffer ram
  function automatic logic [15:0] blk(input logic [2:0] s, input logic [1:0] b);
    return (16'h0008 << s) * b;
  endfunction

  task automatic cmd(input cmd_op_e o, input logic [EP_W-1:0] e, input logic [15:0] dt);
    apb(1'h1, REG_CMD, {9'h0, o, 2'h0, e, dt});
  endtask

  task automatic fl(input logic [EP_W-1:0] e, input int b, input logic x);
    apb(1'h0, REG_STS0 + 12'(4 * e), 32'h0);
    chk("status flag", 32'(x), 32'(rd[b]));
  endtask

  task automatic busy(input logic [EP_W-1:0] e, input logic [1:0] x);
    apb(1'h0, REG_STS0 + 12'(4 * e), 32'h0);
    chk("busy banks", 32'(x), 32'(rd[FL_BUSY_LSB+:2]));
  endtask

  task automatic store(input logic [EP_W-1:0] e, input logic [LEN_W-1:0] l, input logic c, input logic t);
    usb_out_ep <= e;
    usb_out_len <= l;
    usb_out_crc_bad <= c;
    usb_out_toggle_err <= t;
    usb_out_stored <= 1'h1;
    @(posedge clock);
    usb_out_stored <= 1'h0;
    @(posedge clock);
  endtask

  task automatic err_is(input logic [2:0] x);
    apb(1'h0, REG_ERR, 32'h0);
    chk("error bits", 32'(x), rd);
    apb(1'h1, REG_ERR, 32'h7);
  endtask

  initial
  begin
    repeat (4) @(posedge clock);
    reset_n <= 1'h1;
    @(posedge clock);
    fl(0, FL_EN, 1'h0);
    apb(1'h1, REG_STS0, 32'h1);
    chk("status write refused", 32'h1, 32'(sl));
    apb(1'h0, 12'h024, 32'h0);
    chk("unmapped address", 32'h1, 32'(sl));
    cmd(CMD_CFG, 2'h0, cfg(3'h3, 1'h1, EPT_CTRL, 2'h2, 2'h1));
    fl(0, FL_MAPPED, 1'h1);
    cmd(CMD_ENABLE, 2'h0, 16'h0001);
    fl(0, FL_EN, 1'h0);
    usb_end_reset <= 1'h1;
    @(posedge clock);
    usb_end_reset <= 1'h0;
    @(posedge clock);
    fl(0, FL_EN, 1'h1);
    chk("ep0 active", 32'h1, 32'(ep_active[0]));
    store(2'h0, 11'h040, 1'h0, 1'h0);
    fl(0, FL_OUT_RX, 1'h1);
    store(2'h0, 11'h040, 1'h0, 1'h0);
    busy(2'h0, 2'h1);
    cmd(CMD_CLR_OUT, 2'h0, 16'h0);
    fl(0, FL_OUT_RX, 1'h0);
    cmd(CMD_CFG, 2'h1, cfg(3'h7, 1'h0, EPT_BULK, 2'h1, 2'h1));
    err_is(3'h1);
    cmd(CMD_CFG, 2'h1, cfg(3'h3, 1'h0, EPT_BULK, 2'h3, 2'h1));
    fl(1, FL_MAPPED, 1'h0);
    cmd(CMD_ENABLE, 2'h1, 16'h0001);
    err_is(3'h2);
    cmd(CMD_CFG, 2'h1, cfg(3'h3, 1'h0, EPT_BULK, 2'h2, 2'h1));
    cmd(CMD_ENABLE, 2'h1, 16'h0001);
    fl(1, FL_EN, 1'h1);
    store(2'h1, 11'h041, 1'h0, 1'h0);
    fl(1, FL_OUT_RX, 1'h0);
    store(2'h1, 11'h040, 1'h0, 1'h0);
    fl(1, FL_OUT_RX, 1'h1);
    chk("out irq", 32'h1, 32'(lnk.ep_irq[1]));
    store(2'h1, 11'h008, 1'h0, 1'h0);
    busy(2'h1, 2'h2);
    cmd(CMD_CLR_OUT, 2'h1, 16'h0);
    fl(1, FL_OUT_RX, 1'h1);
    cmd(CMD_CLR_OUT, 2'h1, 16'h0);
    fl(1, FL_OUT_RX, 1'h0);
    repeat (6)
    begin
      a = 16'($random(seed)) & 16'hfffc;
      d = $random(seed);
      apb(1'h1, REG_WIN_ADDR, {14'h0, 2'h1, a});
      apb(1'h1, REG_WIN_DATA, d);
      apb(1'h1, REG_WIN_ADDR, {14'h0, 2'h1, 16'(a + blk(3'h3, 2'h2) * 16'($random(seed) & 7))});
      apb(1'h0, REG_WIN_DATA, 32'h0);
      chk("window alias", d, rd);
    end
    store(2'h1, 11'h040, 1'h0, 1'h0);
    cmd(CMD_RESET, 2'h1, 16'h0);
    fl(1, FL_OUT_RX, 1'h0);
    cmd(CMD_CFG, 2'h2, cfg(3'h2, 1'h1, EPT_BULK, 2'h2, 2'h1));
    cmd(CMD_ENABLE, 2'h2, 16'h0002);
    cmd(CMD_SET_IN, 2'h2, 16'h0);
    cmd(CMD_SET_IN, 2'h2, 16'h0);
    fl(2, FL_IN_RDY, 1'h1);
    usb_in_ep <= 2'h2;
    usb_in_sent <= 1'h1;
    @(posedge clock);
    usb_in_sent <= 1'h0;
    @(posedge clock);
    fl(2, FL_IN_RDY, 1'h0);
    fl(2, FL_IN_DONE, 1'h1);
    chk("in irq", 32'h1, 32'(lnk.ep_irq[2]));
    cmd(CMD_CLR_DONE, 2'h2, 16'h0);
    fl(2, FL_IN_DONE, 1'h0);
    usb_in_sending <= 4'h4;
    usb_in_token <= 1'h1;
    @(posedge clock);
    usb_in_token <= 1'h0;
    cmd(CMD_KILL, 2'h2, 16'h0);
    busy(2'h2, 2'h1);
    fl(2, FL_IN_DONE, 1'h1);
    usb_in_sending <= 4'h0;
    cmd(CMD_KILL, 2'h2, 16'h0);
    busy(2'h2, 2'h0);
    cmd(CMD_DISABLE, 2'h2, 16'h0);
    fl(2, FL_EN, 1'h0);
    cmd(CMD_CFG, 2'h3, cfg(3'h4, 1'h0, EPT_ISO, 2'h1, 2'h2));
    cmd(CMD_ENABLE, 2'h3, 16'h0);
    store(2'h3, 11'h010, 1'h1, 1'h0);
    fl(3, FL_CRC, 1'h1);
    store(2'h3, 11'h010, 1'h0, 1'h0);
    fl(3, FL_FLOW, 1'h1);
    cmd(CMD_CLR_OUT, 2'h3, 16'h0);
    store(2'h3, 11'h010, 1'h0, 1'h1);
    fl(3, FL_CRC, 1'h0);
    fl(3, FL_TRERR, 1'h1);
    usb_bus_reset <= 1'h1;
    @(posedge clock);
    usb_bus_reset <= 1'h0;
    @(posedge clock);
    fl(3, FL_TRERR, 1'h0);
    fl(0, FL_EN, 1'h0);
    final_report();
  end
endmodule // testbench
